// *** rail_mode_resolver.sv ***
`timescale 1ns/1ns
module rail_mode_resolver
	import regulator_settings_pkg::*;
(
	input wire logic [1:0] mode_code_in,
	input wire logic setting_mode_bit_in,
	input wire logic shedding_enable_in,
	input wire logic [2:0] pwm_phases_in,
	output op_mode_t mode_out,
	output logic shedding_out,
	output logic [2:0] phases_out
);

	// ------------------------------------------------------------
	// Mode selection
	// ------------------------------------------------------------
	always_comb begin
		unique case (mode_code_in)
			MODE_FROM_SETTING:
				mode_out = setting_mode_bit_in ? OP_AUTO : OP_PWM;
			MODE_AUTO_SINGLE: mode_out = OP_AUTO_SINGLE;
			MODE_FORCED_PWM: mode_out = OP_PWM;
			MODE_AUTO: mode_out = OP_AUTO;
		endcase
	end

	// ------------------------------------------------------------
	// Shedding and phase count
	// ------------------------------------------------------------
	always_comb begin
		shedding_out = shedding_enable_in && (mode_out == OP_PWM);
		phases_out = (mode_out == OP_AUTO_SINGLE) ? 3'h1 : pwm_phases_in;
	end

endmodule : rail_mode_resolver

// *** regulator_settings_pkg.sv ***
package regulator_settings_pkg;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] PHASE_CURRENT_LIMIT_ADDR = 8'hd0;
	localparam logic [7:0] RAIL_A_RAMP_AND_MODE_ADDR = 8'hd1;
	localparam logic [7:0] RAIL_B_RAMP_AND_MODE_ADDR = 8'hd2;
	localparam logic [7:0] PHASE_SHEDDING_AND_COUNT_ADDR = 8'hd3;
	localparam logic [7:0] RAIL_A_VOLTAGE_CEILING_ADDR = 8'hd5;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] CURRENT_LIMIT_RESET = 8'h00;
	localparam logic [7:0] RAMP_AND_MODE_RESET = 8'h00;
	localparam logic [7:0] SHEDDING_AND_COUNT_RESET = 8'h00;
	localparam logic [7:0] CEILING_RESET = 8'h7f;
	localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

	// ------------------------------------------------------------
	// Field layouts
	// ------------------------------------------------------------
	typedef struct packed {
		logic [3:0] rail_b_phase_limit;
		logic [3:0] rail_a_phase_limit;
	} current_limit_t;

	typedef struct packed {
		logic [2:0] falling_slew;
		logic [2:0] rising_slew;
		logic [1:0] operating_mode;
	} ramp_and_mode_t;

	typedef struct packed {
		logic [2:0] reserved;
		logic rail_b_shedding_enable;
		logic rail_a_shedding_enable;
		logic rail_b_phase_sel;
		logic [1:0] rail_a_phase_sel;
	} shedding_and_count_t;

	typedef struct packed {
		logic reserved;
		logic [6:0] rail_a_ceiling_code;
	} ceiling_t;

	// ------------------------------------------------------------
	// Codes and scales
	// ------------------------------------------------------------
	localparam logic [12:0] LIMIT_BASE_MA = 13'h0fa0;
	localparam logic [12:0] LIMIT_STEP_MA = 13'h00c8;
	localparam logic [10:0] VOLT_BASE_MV = 11'h12c;
	localparam logic [10:0] VOLT_STEP_MV = 11'h00a;
	localparam logic [2:0] SLEW_SPECIAL_CODE = 3'h7;
	// Slew rates in units of 10 uV/us
	localparam logic [11:0] SLEW_RATE_0 = 12'h07d;
	localparam logic [11:0] SLEW_RATE_1 = 12'h0fa;
	localparam logic [11:0] SLEW_RATE_2 = 12'h1f4;
	localparam logic [11:0] SLEW_RATE_3 = 12'h3e8;
	localparam logic [11:0] SLEW_RATE_4 = 12'h7d0;
	localparam logic [11:0] SLEW_RATE_5 = 12'hbb8;
	localparam logic [11:0] SLEW_RATE_6 = 12'hfa0;
	localparam logic [1:0] MODE_FROM_SETTING = 2'h0;
	localparam logic [1:0] MODE_AUTO_SINGLE = 2'h1;
	localparam logic [1:0] MODE_FORCED_PWM = 2'h2;
	localparam logic [1:0] MODE_AUTO = 2'h3;
	localparam logic [1:0] RAIL_A_PHASE_SEL_TWO = 2'h1;
	localparam logic [1:0] RAIL_A_PHASE_SEL_THREE = 2'h2;
	localparam logic [2:0] MAX_PHASES_SMALL_VARIANT = 3'h2;

	typedef enum logic [1:0] {
		OP_PWM,
		OP_AUTO,
		OP_AUTO_SINGLE
	} op_mode_t;

	typedef struct packed {
		logic [12:0] limit_ma;
		logic [11:0] fall_rate;
		logic fall_reserved;
		logic [11:0] rise_rate;
		logic rise_immediate;
		op_mode_t mode;
		logic shedding;
		logic [2:0] phases;
		logic uneven_shift;
	} rail_ctrl_t;

	function automatic logic [12:0] limit_ma_of(input logic [3:0] code);
		limit_ma_of = LIMIT_BASE_MA + 13'(LIMIT_STEP_MA * {9'h000, code});
	endfunction : limit_ma_of

	function automatic logic [10:0] voltage_mv_of(input logic [6:0] code);
		voltage_mv_of = VOLT_BASE_MV + 11'(VOLT_STEP_MV * {4'h0, code});
	endfunction : voltage_mv_of

endpackage : regulator_settings_pkg

// *** regulator_settings_props.sv ***
`timescale 1ns/1ns
module regulator_settings_props
	import regulator_settings_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic test_mode_in,
	input wire logic four_phase_variant_in,
	input wire logic otp_load_in,
	input wire logic [6:0] otp_ceiling_in,
	input wire logic rail_a_setting_mode_bit_in,
	input wire logic rail_b_setting_mode_bit_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic reg_rvalid_out,
	input wire rail_ctrl_t rail_a_ctrl_out,
	input wire rail_ctrl_t rail_b_ctrl_out,
	input wire logic [6:0] rail_a_ceiling_code_out,
	input wire logic [10:0] rail_a_ceiling_mv_out
);
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (rst_in);
	// ------------------------------------------------------------
	// Write sequences
	// ------------------------------------------------------------
	sequence wr_limit;
		reg_wr_in && reg_addr_in == PHASE_CURRENT_LIMIT_ADDR;
	endsequence
	sequence wr_ramp_a;
		reg_wr_in && reg_addr_in == RAIL_A_RAMP_AND_MODE_ADDR;
	endsequence
	sequence wr_ramp_b;
		reg_wr_in && reg_addr_in == RAIL_B_RAMP_AND_MODE_ADDR;
	endsequence
	sequence wr_phase;
		reg_wr_in && reg_addr_in == PHASE_SHEDDING_AND_COUNT_ADDR;
	endsequence
	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	chk_limit_rail_b: assert property (wr_limit |-> ##2
		rail_b_ctrl_out.limit_ma == 13'(4000 + 200 * $past(reg_wdata_in[7:4], 2)))
		else $error("rail b limit wrong");
	chk_limit_rail_a: assert property (wr_limit |-> ##2
		rail_a_ctrl_out.limit_ma == 13'(4000 + 200 * $past(reg_wdata_in[3:0], 2)))
		else $error("rail a limit wrong");
	chk_rise_now_a: assert property ((wr_ramp_a ##0 reg_wdata_in[4:2] == 3'h7)
		|-> ##2 rail_a_ctrl_out.rise_immediate) else $error("rail a rise flag");
	chk_fall_rsvd_a: assert property ((wr_ramp_a ##0 reg_wdata_in[7:5] == 3'h7)
		|-> ##2 rail_a_ctrl_out.fall_reserved) else $error("rail a fall flag");
	chk_pwm_mode_a: assert property ((wr_ramp_a ##0 reg_wdata_in[1:0] == 2'h2)
		|-> ##2 rail_a_ctrl_out.mode == OP_PWM) else $error("rail a mode");
	chk_fall_rsvd_b: assert property ((wr_ramp_b ##0 reg_wdata_in[7:5] == 3'h7)
		|-> ##2 rail_b_ctrl_out.fall_reserved) else $error("rail b fall flag");
	chk_rise_now_b: assert property ((wr_ramp_b ##0 reg_wdata_in[4:2] == 3'h7)
		|-> ##2 rail_b_ctrl_out.rise_immediate) else $error("rail b rise flag");
	chk_single_mode_b: assert property ((wr_ramp_b ##0 reg_wdata_in[1:0] == 2'h1)
		|-> ##2 rail_b_ctrl_out.mode == OP_AUTO_SINGLE) else $error("rail b mode");
	chk_shed_pwm_b: assert property (rail_b_ctrl_out.shedding
		|-> rail_b_ctrl_out.mode == OP_PWM) else $error("rail b shedding");
	chk_shed_pwm_a: assert property (rail_a_ctrl_out.shedding
		|-> rail_a_ctrl_out.mode == OP_PWM) else $error("rail a shedding");
	chk_one_phase_b: assert property ((wr_phase ##0 !reg_wdata_in[2])
		|-> ##2 rail_b_ctrl_out.phases == 3'h1) else $error("rail b phases");
	chk_one_phase_a: assert property ((wr_phase ##0 reg_wdata_in[1:0] == 2'h0)
		|-> ##2 rail_a_ctrl_out.phases == 3'h1) else $error("rail a phases");
	chk_phase_cap: assert property (!four_phase_variant_in
		|-> rail_a_ctrl_out.phases <= 3'h2) else $error("phase cap broken");
	chk_ceiling_ro: assert property ($changed(rail_a_ceiling_code_out)
		|-> $past(otp_load_in) || $past(otp_load_in, 2) || $past(test_mode_in, 3))
		else $error("ceiling changed without cause");
	chk_ceiling_mv: assert property (rail_a_ceiling_mv_out ==
		11'(300 + 10 * rail_a_ceiling_code_out)) else $error("ceiling mv wrong");
endmodule : regulator_settings_props

bind regulator_settings_regs regulator_settings_props i_regulator_settings_props (
	.core_clk_in(core_clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
	.reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
	.test_mode_in(test_mode_in), .four_phase_variant_in(four_phase_variant_in),
	.otp_load_in(otp_load_in), .otp_ceiling_in(otp_ceiling_in),
	.rail_a_setting_mode_bit_in(rail_a_setting_mode_bit_in),
	.rail_b_setting_mode_bit_in(rail_b_setting_mode_bit_in),
	.reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
	.rail_a_ctrl_out(rail_a_ctrl_out), .rail_b_ctrl_out(rail_b_ctrl_out),
	.rail_a_ceiling_code_out(rail_a_ceiling_code_out),
	.rail_a_ceiling_mv_out(rail_a_ceiling_mv_out));

// *** regulator_settings_regs.sv ***
`timescale 1ns/1ns
module regulator_settings_regs
	import regulator_settings_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic test_mode_in,
	input wire logic four_phase_variant_in,
	input wire logic otp_load_in,
	input wire logic [6:0] otp_ceiling_in,
	input wire logic rail_a_setting_mode_bit_in,
	input wire logic rail_b_setting_mode_bit_in,
	output logic [7:0] reg_rdata_out,
	output logic reg_rvalid_out,
	output rail_ctrl_t rail_a_ctrl_out,
	output rail_ctrl_t rail_b_ctrl_out,
	output logic [6:0] rail_a_ceiling_code_out,
	output logic [10:0] rail_a_ceiling_mv_out
);

	// ------------------------------------------------------------
	// Register storage
	// ------------------------------------------------------------
	current_limit_t current_limit_reg;
	ramp_and_mode_t rail_a_ramp_reg;
	ramp_and_mode_t rail_b_ramp_reg;
	shedding_and_count_t shedding_reg;
	ceiling_t ceiling_reg;

	// ------------------------------------------------------------
	// Pin synchronisers and strap
	// ------------------------------------------------------------
	logic test_mode_meta_reg;
	logic test_mode_sync_reg;
	logic variant_meta_reg;
	logic variant_sync_reg;
	logic variant_captured_reg;
	logic four_phase_reg;

	// ------------------------------------------------------------
	// Decoded values
	// ------------------------------------------------------------
	logic [11:0] rail_a_fall_rate;
	logic rail_a_fall_special;
	logic [11:0] rail_a_rise_rate;
	logic rail_a_rise_special;
	logic [11:0] rail_b_fall_rate;
	logic rail_b_fall_special;
	logic [11:0] rail_b_rise_rate;
	logic rail_b_rise_special;
	logic [2:0] rail_a_pwm_phases;
	logic [2:0] rail_b_pwm_phases;
	op_mode_t rail_a_mode;
	op_mode_t rail_b_mode;
	logic rail_a_shedding;
	logic rail_b_shedding;
	logic [2:0] rail_a_phases;
	logic [2:0] rail_b_phases;
	logic [7:0] read_next;
	logic write_limit;
	logic write_rail_a;
	logic write_rail_b;
	logic write_shedding;
	logic write_ceiling;

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	always_comb begin
		write_limit = reg_wr_in && (reg_addr_in == PHASE_CURRENT_LIMIT_ADDR);
		write_rail_a = reg_wr_in && (reg_addr_in == RAIL_A_RAMP_AND_MODE_ADDR);
		write_rail_b = reg_wr_in && (reg_addr_in == RAIL_B_RAMP_AND_MODE_ADDR);
		write_shedding = reg_wr_in &&
			(reg_addr_in == PHASE_SHEDDING_AND_COUNT_ADDR);
		write_ceiling = reg_wr_in &&
			(reg_addr_in == RAIL_A_VOLTAGE_CEILING_ADDR);
	end

	// ------------------------------------------------------------
	// Test mode synchroniser
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			test_mode_meta_reg <= 1'b0;
			test_mode_sync_reg <= 1'b0;
		end else begin
			test_mode_meta_reg <= test_mode_in;
			test_mode_sync_reg <= test_mode_meta_reg;
		end
	end

	// ------------------------------------------------------------
	// Variant strap synchroniser, free-running through reset
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_in) begin
		variant_meta_reg <= four_phase_variant_in;
		variant_sync_reg <= variant_meta_reg;
	end

	// ------------------------------------------------------------
	// Variant strap, caught once after reset release
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			variant_captured_reg <= 1'b0;
			four_phase_reg <= 1'b0;
		end else if (!variant_captured_reg) begin
			variant_captured_reg <= 1'b1;
			four_phase_reg <= variant_sync_reg;
		end
	end

	// ------------------------------------------------------------
	// Current limit register
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			current_limit_reg <= CURRENT_LIMIT_RESET;
		end else if (write_limit) begin
			current_limit_reg <= reg_wdata_in;
		end
	end

	// ------------------------------------------------------------
	// Rail ramp and mode registers
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			rail_a_ramp_reg <= RAMP_AND_MODE_RESET;
		end else if (write_rail_a) begin
			rail_a_ramp_reg <= reg_wdata_in;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			rail_b_ramp_reg <= RAMP_AND_MODE_RESET;
		end else if (write_rail_b) begin
			rail_b_ramp_reg <= reg_wdata_in;
		end
	end

	// ------------------------------------------------------------
	// Shedding and phase count register
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			shedding_reg <= SHEDDING_AND_COUNT_RESET;
		end else if (write_shedding) begin
			shedding_reg <= reg_wdata_in;
		end
	end

	// ------------------------------------------------------------
	// Rail A ceiling register
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			ceiling_reg <= CEILING_RESET;
		end else if (write_ceiling && test_mode_sync_reg) begin
			ceiling_reg <= reg_wdata_in;
		end else if (write_ceiling) begin
			ceiling_reg.reserved <= reg_wdata_in[7];
		end else if (otp_load_in) begin
			ceiling_reg.rail_a_ceiling_code <= otp_ceiling_in;
		end
	end

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	always_comb begin
		unique case (reg_addr_in)
			PHASE_CURRENT_LIMIT_ADDR: read_next = current_limit_reg;
			RAIL_A_RAMP_AND_MODE_ADDR: read_next = rail_a_ramp_reg;
			RAIL_B_RAMP_AND_MODE_ADDR: read_next = rail_b_ramp_reg;
			PHASE_SHEDDING_AND_COUNT_ADDR: read_next = shedding_reg;
			RAIL_A_VOLTAGE_CEILING_ADDR: read_next = ceiling_reg;
			default: read_next = UNMAPPED_READ_VALUE;
		endcase
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			reg_rdata_out <= UNMAPPED_READ_VALUE;
		end else if (reg_rd_in) begin
			reg_rdata_out <= read_next;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			reg_rvalid_out <= 1'b0;
		end else begin
			reg_rvalid_out <= reg_rd_in;
		end
	end

	// ------------------------------------------------------------
	// Slew rate decoders
	// ------------------------------------------------------------
	slew_rate_decoder rail_a_fall_dec (
		.code_in(rail_a_ramp_reg.falling_slew),
		.rate_out(rail_a_fall_rate),
		.special_out(rail_a_fall_special)
	);

	slew_rate_decoder rail_a_rise_dec (
		.code_in(rail_a_ramp_reg.rising_slew),
		.rate_out(rail_a_rise_rate),
		.special_out(rail_a_rise_special)
	);

	slew_rate_decoder rail_b_fall_dec (
		.code_in(rail_b_ramp_reg.falling_slew),
		.rate_out(rail_b_fall_rate),
		.special_out(rail_b_fall_special)
	);

	slew_rate_decoder rail_b_rise_dec (
		.code_in(rail_b_ramp_reg.rising_slew),
		.rate_out(rail_b_rise_rate),
		.special_out(rail_b_rise_special)
	);

	// ------------------------------------------------------------
	// PWM phase counts
	// ------------------------------------------------------------
	always_comb begin
		rail_a_pwm_phases = 3'({1'b0, shedding_reg.rail_a_phase_sel} + 3'h1);
		if (!four_phase_reg &&
			(shedding_reg.rail_a_phase_sel > RAIL_A_PHASE_SEL_TWO)) begin
			rail_a_pwm_phases = MAX_PHASES_SMALL_VARIANT;
		end
		rail_b_pwm_phases = shedding_reg.rail_b_phase_sel ? 3'h2 : 3'h1;
	end

	// ------------------------------------------------------------
	// Mode resolution
	// ------------------------------------------------------------
	rail_mode_resolver rail_a_resolver (
		.mode_code_in(rail_a_ramp_reg.operating_mode),
		.setting_mode_bit_in(rail_a_setting_mode_bit_in),
		.shedding_enable_in(shedding_reg.rail_a_shedding_enable),
		.pwm_phases_in(rail_a_pwm_phases),
		.mode_out(rail_a_mode),
		.shedding_out(rail_a_shedding),
		.phases_out(rail_a_phases)
	);

	rail_mode_resolver rail_b_resolver (
		.mode_code_in(rail_b_ramp_reg.operating_mode),
		.setting_mode_bit_in(rail_b_setting_mode_bit_in),
		.shedding_enable_in(shedding_reg.rail_b_shedding_enable),
		.pwm_phases_in(rail_b_pwm_phases),
		.mode_out(rail_b_mode),
		.shedding_out(rail_b_shedding),
		.phases_out(rail_b_phases)
	);

	// ------------------------------------------------------------
	// Rail A control outputs
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			rail_a_ctrl_out <= '0;
		end else begin
			rail_a_ctrl_out.limit_ma <=
				limit_ma_of(current_limit_reg.rail_a_phase_limit);
			rail_a_ctrl_out.fall_rate <= rail_a_fall_rate;
			rail_a_ctrl_out.fall_reserved <= rail_a_fall_special;
			rail_a_ctrl_out.rise_rate <= rail_a_rise_rate;
			rail_a_ctrl_out.rise_immediate <= rail_a_rise_special;
			rail_a_ctrl_out.mode <= rail_a_mode;
			rail_a_ctrl_out.shedding <= rail_a_shedding;
			rail_a_ctrl_out.phases <= rail_a_phases;
			rail_a_ctrl_out.uneven_shift <= (rail_a_phases == 3'h3);
		end
	end

	// ------------------------------------------------------------
	// Rail B control outputs
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			rail_b_ctrl_out <= '0;
		end else begin
			rail_b_ctrl_out.limit_ma <=
				limit_ma_of(current_limit_reg.rail_b_phase_limit);
			rail_b_ctrl_out.fall_rate <= rail_b_fall_rate;
			rail_b_ctrl_out.fall_reserved <= rail_b_fall_special;
			rail_b_ctrl_out.rise_rate <= rail_b_rise_rate;
			rail_b_ctrl_out.rise_immediate <= rail_b_rise_special;
			rail_b_ctrl_out.mode <= rail_b_mode;
			rail_b_ctrl_out.shedding <= rail_b_shedding;
			rail_b_ctrl_out.phases <= rail_b_phases;
			rail_b_ctrl_out.uneven_shift <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Ceiling outputs
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			rail_a_ceiling_code_out <= CEILING_RESET[6:0];
		end else begin
			rail_a_ceiling_code_out <= ceiling_reg.rail_a_ceiling_code;
		end
	end

	// ------------------------------------------------------------
	// Ceiling in millivolts
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			rail_a_ceiling_mv_out <= voltage_mv_of(CEILING_RESET[6:0]);
		end else begin
			rail_a_ceiling_mv_out <=
				voltage_mv_of(ceiling_reg.rail_a_ceiling_code);
		end
	end

endmodule : regulator_settings_regs

// *** regulator_settings_regs_tb.sv ***
`timescale 1ns/1ns
module regulator_settings_regs_tb
	import regulator_settings_pkg::*;
;
	logic core_clk_in = 0, rst_in = 1, reg_wr_in = 0, reg_rd_in = 0;
	logic test_mode_in = 0, otp_load_in = 0, sb_a = 0, sb_b = 0, four_ph = 0;
	logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, seed = 8'h53;
	logic [6:0] otp_ceiling_in = 7'h00;
	logic [7:0] reg_rdata_out;
	logic reg_rvalid_out;
	rail_ctrl_t rail_a_ctrl_out, rail_b_ctrl_out, c;
	logic [6:0] rail_a_ceiling_code_out;
	logic [10:0] rail_a_ceiling_mv_out;
	logic [7:0] exp_q[$];
	logic [11:0] rates[8] = '{12'h07d, 12'h0fa, 12'h1f4, 12'h3e8, 12'h7d0,
		12'hbb8, 12'hfa0, 12'h000};
	int err_count = 0, num_checks = 0;
	regulator_settings_regs i_regulator_settings_regs (
		.core_clk_in(core_clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
		.reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
		.test_mode_in(test_mode_in), .four_phase_variant_in(four_ph),
		.otp_load_in(otp_load_in), .otp_ceiling_in(otp_ceiling_in),
		.rail_a_setting_mode_bit_in(sb_a), .rail_b_setting_mode_bit_in(sb_b),
		.reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
		.rail_a_ctrl_out(rail_a_ctrl_out), .rail_b_ctrl_out(rail_b_ctrl_out),
		.rail_a_ceiling_code_out(rail_a_ceiling_code_out),
		.rail_a_ceiling_mv_out(rail_a_ceiling_mv_out));
	always #25 core_clk_in = ~core_clk_in;
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic check(input string name, input logic [15:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic end_sim;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_sim
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr
	function automatic op_mode_t exp_mode(input logic [1:0] m, input logic b);
		exp_mode = m == 2'h0 ? (b ? OP_AUTO : OP_PWM) : m == 2'h1 ? OP_AUTO_SINGLE :
			m == 2'h2 ? OP_PWM : OP_AUTO;
	endfunction : exp_mode
	task automatic wr(input logic [7:0] a, d);
		@(posedge core_clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge core_clk_in);
		reg_wr_in <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, e);
		@(posedge core_clk_in);
		exp_q.push_back(e);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge core_clk_in);
		reg_rd_in <= 1'b0;
	endtask : rd
	task automatic settle;
		repeat (3) @(posedge core_clk_in);
		#1;
	endtask : settle
	// ------------------------------------------------------------
	// Read monitor and watchdog
	// ------------------------------------------------------------
	always @(posedge core_clk_in) begin
		if (!rst_in && reg_rvalid_out === 1'b1) begin
			if (exp_q.size() == 0)
				check("rdata_extra", 16'h1, 16'h0);
			else
				check("rdata", 16'(reg_rdata_out), 16'(exp_q.pop_front()));
		end
	end
	initial begin
		repeat (20000) @(posedge core_clk_in);
		err_count++;
		end_sim();
	end
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial begin
		repeat (12) @(posedge core_clk_in);
		rst_in <= 1'b0;
		for (int a = 8'hd0; a <= 8'hd6; a++)
			rd(8'(a), a == 8'hd5 ? 8'h7f : 8'h00);
		$display("reset test done");
		for (int i = 0; i < 8; i++) begin
			seed = lfsr(seed);
			wr(8'(8'hd0 + i % 4), seed);
			rd(8'(8'hd0 + i % 4), seed);
		end
		wr(8'hd4, seed);
		rd(8'hd4, 8'h00);
		$display("access test done");
		for (int i = 0; i < 16; i++) begin
			wr(8'hd0, {4'(15 - i), 4'(i)});
			settle();
			check("lim_a", 16'(rail_a_ctrl_out.limit_ma), 16'(4000 + 200 * i));
			check("lim_b", 16'(rail_b_ctrl_out.limit_ma), 16'(7000 - 200 * i));
		end
		$display("limit test done");
		for (int r = 0; r < 2; r++) begin
			for (int k = 0; k < 8; k++) begin
				wr(8'(8'hd1 + r), {3'(k), 3'(7 - k), 2'(k)});
				settle();
				c = r ? rail_b_ctrl_out : rail_a_ctrl_out;
				check("fall", 16'(c.fall_rate), 16'(rates[k]));
				check("fall_rsv", 16'(c.fall_reserved), 16'(k == 7));
				check("rise", 16'(c.rise_rate), 16'(rates[7 - k]));
				check("rise_now", 16'(c.rise_immediate), 16'(k == 0));
				check("mode", 16'(c.mode), 16'(exp_mode(2'(k), 1'b0)));
			end
		end
		@(posedge core_clk_in);
		sb_a <= 1'b1;
		sb_b <= 1'b1;
		wr(8'hd1, 8'h00);
		wr(8'hd2, 8'h00);
		settle();
		check("mode_a", 16'(rail_a_ctrl_out.mode), 16'(OP_AUTO));
		check("mode_b", 16'(rail_b_ctrl_out.mode), 16'(OP_AUTO));
		$display("ramp and mode test done");
		wr(8'hd1, 8'h02);
		wr(8'hd2, 8'h02);
		for (int s = 0; s < 32; s++) begin
			wr(8'hd3, {3'h5, 5'(s)});
			settle();
			check("ph_a", 16'(rail_a_ctrl_out.phases), s % 4 ? 16'h2 : 16'h1);
			check("uneven", 16'(rail_a_ctrl_out.uneven_shift), 16'h0);
			check("ph_b", 16'(rail_b_ctrl_out.phases), 16'(1 + s[2]));
			check("shed_a", 16'(rail_a_ctrl_out.shedding), 16'(s[3]));
			check("shed_b", 16'(rail_b_ctrl_out.shedding), 16'(s[4]));
			rd(8'hd3, {3'h5, 5'(s)});
		end
		wr(8'hd1, 8'h01);
		wr(8'hd2, 8'h03);
		settle();
		check("single_ph", 16'(rail_a_ctrl_out.phases), 16'h1);
		check("shed_auto", 16'(rail_b_ctrl_out.shedding), 16'h0);
		$display("phase test done");
		@(posedge core_clk_in);
		otp_ceiling_in <= 7'h2a;
		otp_load_in <= 1'b1;
		@(posedge core_clk_in);
		otp_load_in <= 1'b0;
		settle();
		check("ceil", 16'(rail_a_ceiling_code_out), 16'h2a);
		check("ceil_mv", 16'(rail_a_ceiling_mv_out), 16'(300 + 10 * 8'h2a));
		wr(8'hd5, 8'h85);
		rd(8'hd5, 8'haa);
		settle();
		check("ceil_ro", 16'(rail_a_ceiling_code_out), 16'h2a);
		@(posedge core_clk_in);
		test_mode_in <= 1'b1;
		repeat (4) @(posedge core_clk_in);
		wr(8'hd5, 8'h11);
		rd(8'hd5, 8'h11);
		settle();
		check("ceil_tm", 16'(rail_a_ceiling_code_out), 16'h11);
		check("ceil_mv", 16'(rail_a_ceiling_mv_out), 16'(300 + 10 * 8'h11));
		@(posedge core_clk_in);
		test_mode_in <= 1'b0;
		$display("ceiling test done");
		four_ph <= 1'b1;
		rst_in <= 1'b1;
		repeat (4) @(posedge core_clk_in);
		rst_in <= 1'b0;
		rd(8'hd5, 8'h7f);
		for (int s = 2; s < 4; s++) begin
			wr(8'hd3, 8'(s));
			settle();
			check("ph_a4", 16'(rail_a_ctrl_out.phases), 16'(s + 1));
			check("uneven3", 16'(rail_a_ctrl_out.uneven_shift), 16'(s == 2));
		end
		$display("variant test done");
		repeat (4) @(posedge core_clk_in);
		check("pending", 16'(exp_q.size()), 16'h0);
		end_sim();
	end
endmodule : regulator_settings_regs_tb

// *** slew_rate_decoder.sv ***
`timescale 1ns/1ns
module slew_rate_decoder
	import regulator_settings_pkg::*;
(
	input wire logic [2:0] code_in,
	output logic [11:0] rate_out,
	output logic special_out
);

	// ------------------------------------------------------------
	// Code to rate
	// ------------------------------------------------------------
	always_comb begin
		special_out = 1'b0;
		unique case (code_in)
			3'h0: rate_out = SLEW_RATE_0;
			3'h1: rate_out = SLEW_RATE_1;
			3'h2: rate_out = SLEW_RATE_2;
			3'h3: rate_out = SLEW_RATE_3;
			3'h4: rate_out = SLEW_RATE_4;
			3'h5: rate_out = SLEW_RATE_5;
			3'h6: rate_out = SLEW_RATE_6;
			3'h7: begin
				rate_out = 12'h000;
				special_out = 1'b1;
			end
		endcase
	end

endmodule : slew_rate_decoder
